// file: hdl/sdcsl_bank.sv
// One bank's state and wait counter.
// Assumes the parent has already decoded and qualified the command.
`timescale 1ns/100ps
module sdcsl_bank
    import sdcsl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_sel,
    input wire logic i_go,
    input wire sdcsl_cmd_e i_cmd,
    input wire logic i_close_all,
    output sdcsl_bank_e o_state,
    output logic o_illegal
);

    logic [CNT_W-1:0] wait_cnt;
    logic hit;

    assign hit = i_go && (i_sel || (i_cmd == CMD_PRECHARGE && i_close_all));

    // In the wait states, only NOP-class or, while precharging, precharge itself are tolerated
    always_comb begin
        o_illegal = 1'b0;
        if (i_go && i_sel) begin
            case (o_state)
                BANK_PRECHARGING: o_illegal = (i_cmd != CMD_NOP) && (i_cmd != CMD_PRECHARGE); // RULE_01 RULE_05
                BANK_ACTIVATING: o_illegal = (i_cmd != CMD_NOP); // RULE_02 RULE_05
                BANK_IDLE: o_illegal = (i_cmd inside {CMD_READ, CMD_WRITE, CMD_BURST_STOP});
                BANK_ROW_ACTIVE: o_illegal = (i_cmd == CMD_ACTIVATE) || (i_cmd == CMD_BURST_STOP);
                default: o_illegal = (i_cmd == CMD_ACTIVATE);
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_state <= BANK_IDLE;
            wait_cnt <= '0;
        end else begin
            case (o_state)
                BANK_IDLE: begin
                    if (hit && i_sel && i_cmd == CMD_ACTIVATE) begin
                        o_state <= BANK_ACTIVATING;
                        wait_cnt <= CNT_W'(ACTIVATE_TO_COLUMN_WAIT_CYC - 1);
                    end
                end
                BANK_ACTIVATING: begin
                    if (wait_cnt == '0) begin
                        o_state <= BANK_ROW_ACTIVE; // RULE_02
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                BANK_PRECHARGING: begin
                    if (wait_cnt == '0) begin
                        o_state <= BANK_IDLE; // RULE_01
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                default: begin
                    if (hit && i_cmd == CMD_PRECHARGE) begin
                        o_state <= BANK_PRECHARGING;
                        wait_cnt <= CNT_W'(PRECHARGE_WAIT_CYC - 1);
                    end else if (hit && i_sel && (i_cmd == CMD_READ || i_cmd == CMD_WRITE)) begin
                        o_state <= BANK_BURST;
                    end else if (hit && i_sel && i_cmd == CMD_BURST_STOP) begin
                        o_state <= BANK_ROW_ACTIVE; // RULE_20
                    end
                end
            endcase
        end
    end

endmodule

// file: hdl/sdcsl_pkg.sv
// Constants and carrier types for the SDRAM command-state logic.
// Assumes a single 10 MHz clock domain; no register bus.
//
// Behaviour
// RULE_01 - Precharging bank: NOP/precharge wait, then idle
// RULE_02 - Activating bank: only NOP, then row active
// RULE_03 - Mode register access: idle two clocks later
// RULE_04 - Bank decode only when enable high twice
// RULE_05 - Illegality judged per bank by bank select
// RULE_06 - Refresh/mode access only with all banks idle
// RULE_07 - Self refresh held while enable low; exit wait
// RULE_08 - Self refresh exit detected without system clock
// RULE_09 - Power down exit to all idle, setup allowed
// RULE_10 - Power down exit asynchronous; low holds it
// RULE_11 - Power down/self refresh entry only all idle
// RULE_12 - Clock suspend begins/ends next cycle
// RULE_13 - Controller holds enable high during power-up
// RULE_14 - Controller waits 200 us stable NOP
// RULE_15 - Init: precharge all, two refresh, mode load
// RULE_16 - Extended mode load after normal, optional
// RULE_17 - Default half drive, all four banks refreshed
// RULE_18 - Extended mode change only with banks idle
// RULE_19 - Command encoding of strobes decoded
// RULE_20 - Burst terminate returns bank to row active
// RULE_21 - Controller never issues illegal commands; the bench issues some to test the flag
package sdcsl_pkg;

    localparam int NUM_BANKS = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PRECHARGE_WAIT_NS = 20;
    localparam int ACTIVATE_TO_COLUMN_WAIT_NS = 20;
    localparam int ROW_CYCLE_WAIT_NS = 80;
    localparam int SELFREFRESH_EXIT_WAIT_NS = 120;
    localparam int MODE_ACCESS_CLOCKS = 2;
    localparam int POWERUP_WAIT_US = 200;
    // Least times round up, never below one cycle
    localparam int PRECHARGE_WAIT_CYC = (PRECHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACTIVATE_TO_COLUMN_WAIT_CYC = (ACTIVATE_TO_COLUMN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_CYCLE_WAIT_CYC = (ROW_CYCLE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELFREFRESH_EXIT_WAIT_CYC = (SELFREFRESH_EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [1:0] DRIVE_STRENGTH_HALF = 2'h1;
    localparam logic [2:0] PARTIAL_ARRAY_ALL = 3'h0;
    localparam int EXT_DRIVE_LSB = 5;
    localparam int EXT_PARTIAL_LSB = 0;

    typedef enum logic [2:0] {
        BANK_IDLE = 3'b000,
        BANK_ACTIVATING = 3'b001,
        BANK_ROW_ACTIVE = 3'b010,
        BANK_BURST = 3'b011,
        BANK_PRECHARGING = 3'b100
    } sdcsl_bank_e;

    typedef enum logic [2:0] {
        DEV_ALL_IDLE = 3'b000,
        DEV_ACTIVE = 3'b001,
        DEV_MODE_ACCESS = 3'b010,
        DEV_POWER_DOWN = 3'b011,
        DEV_SELF_REFRESH = 3'b100,
        DEV_SR_EXIT = 3'b101,
        DEV_REFRESHING = 3'b110
    } sdcsl_dev_e;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_ACTIVATE = 4'h1,
        CMD_READ = 4'h2,
        CMD_WRITE = 4'h3,
        CMD_PRECHARGE = 4'h4,
        CMD_REFRESH = 4'h5,
        CMD_MODE_LOAD = 4'h6,
        CMD_BURST_STOP = 4'h7
    } sdcsl_cmd_e;

    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic [1:0] bank_sel;
        logic auto_close_flag;
        logic [7:0] addr_low;
    } sdcsl_pins_s;

    typedef struct packed {
        logic [1:0] drive_strength_sel;
        logic [2:0] partial_array_refresh;
    } sdcsl_ext_mode_s;

endpackage

// file: hdl/sdcsl_top.sv
// Command-state logic of a mobile SDRAM die.
// Assumes command pins arrive from a controller on i_clock; the enable pin
// is also watched through a synchroniser for low-power exits.
`timescale 1ns/100ps
module sdcsl_top
    import sdcsl_pkg::*;
#(
    parameter int BANKS = NUM_BANKS
)
(
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_clk_en,
    input wire sdcsl_pins_s i_pins,
    output sdcsl_dev_e o_dev_state,
    output sdcsl_bank_e o_bank_state [BANKS],
    output logic o_illegal,
    output logic o_clock_suspend,
    output logic o_all_idle,
    output sdcsl_ext_mode_s o_ext_mode
);

    // ----------------------------------------
    // Enable pin history and asynchronous wake
    // ----------------------------------------
    logic cke_prev;
    logic [2:0] cke_sync;
    logic wake;
    logic low_seen;
    sdcsl_cmd_e cmd;
    logic go;
    logic [BANKS-1:0] bank_ill;
    logic [BANKS-1:0] bank_idle;
    logic is_nop;
    logic all_idle;
    logic [CNT_W-1:0] dev_cnt;
    logic cmd_ill;
    sdcsl_dev_e next_dev;

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            cke_prev <= 1'b1;
            cke_sync <= 3'b111;
        end else begin
            cke_prev <= i_clk_en;
            cke_sync <= {cke_sync[1:0], i_clk_en};
        end
    end

    // A wake counts only once the synchronised pin has been seen low in the
    // low-power state: on entry the pipeline still holds the old high level.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            low_seen <= 1'b0;
        end else if (o_dev_state != DEV_SELF_REFRESH && o_dev_state != DEV_POWER_DOWN) begin
            low_seen <= 1'b0;
        end else if (!cke_sync[2] && !cke_sync[1]) begin
            low_seen <= 1'b1;
        end
    end

    // Wake needs no running command decode; the synchronised level alone
    // ends self refresh or power down, since the controller's clock may
    // only just have restarted.
    assign wake = low_seen && cke_sync[2] && cke_sync[1]; // RULE_08 RULE_10

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    always_comb begin
        if (i_pins.cs_b) begin
            cmd = CMD_NOP;
        end else begin
            case ({i_pins.ras_b, i_pins.cas_b, i_pins.we_b}) // RULE_19
                3'b111: cmd = CMD_NOP;
                3'b011: cmd = CMD_ACTIVATE;
                3'b100: cmd = CMD_WRITE;
                3'b101: cmd = CMD_READ;
                3'b010: cmd = CMD_PRECHARGE;
                3'b001: cmd = CMD_REFRESH;
                3'b000: cmd = CMD_MODE_LOAD;
                default: cmd = CMD_BURST_STOP; // RULE_20
            endcase
        end
    end

    assign is_nop = (cmd == CMD_NOP);
    assign go = cke_prev && i_clk_en && (o_dev_state == DEV_ALL_IDLE || o_dev_state == DEV_ACTIVE); // RULE_04

    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_bank
            sdcsl_bank u_bank (
                .i_clock(i_clock),
                .i_rst_b(i_rst_b),
                .i_sel(i_pins.bank_sel == 2'(g)), // RULE_05
                .i_go(go),
                .i_cmd(cmd),
                .i_close_all(i_pins.auto_close_flag),
                .o_state(o_bank_state[g]),
                .o_illegal(bank_ill[g])
            );
            assign bank_idle[g] = (o_bank_state[g] == BANK_IDLE);
        end
    endgenerate

    assign all_idle = &bank_idle;
    assign o_all_idle = all_idle && (o_dev_state == DEV_ALL_IDLE || o_dev_state == DEV_ACTIVE);

    // ----------------------------------------
    // Illegal command flag
    // ----------------------------------------
    always_comb begin
        cmd_ill = 1'b0;
        case (o_dev_state)
            DEV_MODE_ACCESS: cmd_ill = !is_nop; // RULE_03
            DEV_REFRESHING: cmd_ill = !is_nop && cmd != CMD_BURST_STOP;
            DEV_SR_EXIT: cmd_ill = !is_nop; // RULE_07
            DEV_SELF_REFRESH, DEV_POWER_DOWN: cmd_ill = !cke_prev && i_clk_en && !is_nop; // RULE_07 RULE_09
            default: begin
                if (go) begin
                    cmd_ill = |bank_ill;
                    if ((cmd == CMD_REFRESH || cmd == CMD_MODE_LOAD) && !all_idle) begin
                        cmd_ill = 1'b1; // RULE_06
                    end
                end else if (cke_prev && !i_clk_en && all_idle && !is_nop
                             && cmd != CMD_REFRESH && cmd != CMD_ACTIVATE && cmd != CMD_MODE_LOAD) begin
                    cmd_ill = 1'b1; // RULE_11
                end
            end
        endcase
    end
    assign o_illegal = cmd_ill;

    // ----------------------------------------
    // Device state
    // ----------------------------------------
    always_comb begin
        next_dev = o_dev_state;
        case (o_dev_state)
            DEV_ALL_IDLE, DEV_ACTIVE: begin
                if (cke_prev && !i_clk_en && all_idle) begin
                    if (is_nop) begin
                        next_dev = DEV_POWER_DOWN; // RULE_11
                    end else if (cmd == CMD_REFRESH) begin
                        next_dev = DEV_SELF_REFRESH; // RULE_11
                    end
                end else if (go && all_idle && cmd == CMD_MODE_LOAD) begin
                    next_dev = DEV_MODE_ACCESS;
                end else if (go && all_idle && cmd == CMD_REFRESH) begin
                    next_dev = DEV_REFRESHING;
                end else begin
                    next_dev = all_idle ? DEV_ALL_IDLE : DEV_ACTIVE;
                end
            end
            DEV_MODE_ACCESS, DEV_REFRESHING, DEV_SR_EXIT: begin
                if (dev_cnt == '0) begin
                    next_dev = DEV_ALL_IDLE; // RULE_03 RULE_07
                end
            end
            DEV_SELF_REFRESH: begin
                if (wake) begin
                    next_dev = DEV_SR_EXIT; // RULE_07
                end
            end
            DEV_POWER_DOWN: begin
                if (wake) begin
                    next_dev = DEV_ALL_IDLE; // RULE_09 RULE_10
                end
            end
            default: next_dev = DEV_ALL_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_dev_state <= DEV_ALL_IDLE;
            dev_cnt <= '0;
        end else begin
            o_dev_state <= next_dev;
            if (next_dev == DEV_MODE_ACCESS && o_dev_state != DEV_MODE_ACCESS) begin
                dev_cnt <= CNT_W'(MODE_ACCESS_CLOCKS - 1);
            end else if (next_dev == DEV_REFRESHING && o_dev_state != DEV_REFRESHING) begin
                dev_cnt <= CNT_W'(ROW_CYCLE_WAIT_CYC - 1);
            end else if (next_dev == DEV_SR_EXIT && o_dev_state != DEV_SR_EXIT) begin
                dev_cnt <= CNT_W'(SELFREFRESH_EXIT_WAIT_CYC - 1);
            end else if (dev_cnt != '0) begin
                dev_cnt <= dev_cnt - 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Clock suspend in active states
    // ----------------------------------------
    // Suspend flag lags the enable by one cycle, so it starts and ends next cycle
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_clock_suspend <= 1'b0;
        end else if ((o_dev_state == DEV_ALL_IDLE || o_dev_state == DEV_ACTIVE) && !all_idle) begin
            // Device state trails the banks by a cycle, so open banks decide
            o_clock_suspend <= !i_clk_en; // RULE_12
        end else begin
            o_clock_suspend <= 1'b0;
        end
    end

    // ----------------------------------------
    // Extended mode word
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_ext_mode.drive_strength_sel <= DRIVE_STRENGTH_HALF; // RULE_17
            o_ext_mode.partial_array_refresh <= PARTIAL_ARRAY_ALL; // RULE_17
        end else if (go && cmd == CMD_MODE_LOAD && all_idle && i_pins.bank_sel[1]) begin
            o_ext_mode.drive_strength_sel <= i_pins.addr_low[EXT_DRIVE_LSB +: 2]; // RULE_18
            o_ext_mode.partial_array_refresh <= i_pins.addr_low[EXT_PARTIAL_LSB +: 3]; // RULE_18
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_mode_load;
        go && all_idle && cmd == CMD_MODE_LOAD && !(cke_prev && !i_clk_en);
    endsequence

    a_mode_return_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_03
        s_mode_load |=> (o_dev_state == DEV_MODE_ACCESS) ##1 (o_dev_state == DEV_MODE_ACCESS)
        ##1 (o_dev_state == DEV_ALL_IDLE))
        else $error("mode access did not end after two clocks");
    a_self_ref_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_07
        (o_dev_state == DEV_SELF_REFRESH && !cke_sync[1]) |=> o_dev_state == DEV_SELF_REFRESH)
        else $error("self refresh left while enable low");
    a_sr_exit_wait: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_08
        (o_dev_state == DEV_SELF_REFRESH && wake) |=> (o_dev_state == DEV_SR_EXIT) [*1] ##[0:3] o_all_idle)
        else $error("self refresh exit not completed");
    a_pd_exit: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_10
        (o_dev_state == DEV_POWER_DOWN && wake) |=> o_dev_state == DEV_ALL_IDLE)
        else $error("power down exit missed");
    a_lowpower_entry: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_11
        ($changed(o_dev_state) && (o_dev_state == DEV_POWER_DOWN || o_dev_state == DEV_SELF_REFRESH))
        |-> $past(all_idle))
        else $error("low power entered with bank open");
    a_suspend_next: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_12
        (o_dev_state == DEV_ACTIVE && !all_idle && !i_clk_en) |=> o_clock_suspend)
        else $error("clock suspend did not begin");
    a_gated_decode: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_04
        (!cke_prev && o_dev_state == DEV_ACTIVE) |=> $stable(o_bank_state[0]) || o_bank_state[0] != BANK_ACTIVATING)
        else $error("bank command decoded with enable low");
    a_refresh_allidle: assert property (@(posedge i_clock) disable iff (!i_rst_b) // RULE_06
        (go && (cmd == CMD_REFRESH || cmd == CMD_MODE_LOAD) && !all_idle) |-> o_illegal)
        else $error("refresh with open bank not flagged");

endmodule

// file: verification/sdcsl_ctrl_model.sv
// Memory controller model: encodes command requests onto the strobe pins.
// Assumes the bench changes its requests just after the rising clock edge.
`timescale 1ns/100ps
module sdcsl_ctrl_model
    import sdcsl_pkg::*;
(
    input wire logic i_clock,
    input wire sdcsl_cmd_e i_cmd,
    input wire logic [1:0] i_bank,
    input wire logic i_close_all,
    input wire logic [7:0] i_addr,
    input wire logic i_cke,
    output logic o_clk_en,
    output sdcsl_pins_s o_pins
);
    logic toggle = 1'b0;
    logic [2:0] strobes;

    // Lines that no command qualifies get a moving pattern, not a stale value
    always_ff @(posedge i_clock) begin
        toggle <= ~toggle;
    end

    always_comb begin
        case (i_cmd)
            CMD_ACTIVATE: strobes = 3'b011;
            CMD_READ: strobes = 3'b101;
            CMD_WRITE: strobes = 3'b100;
            CMD_PRECHARGE: strobes = 3'b010;
            CMD_REFRESH: strobes = 3'b001;
            CMD_MODE_LOAD: strobes = 3'b000;
            CMD_BURST_STOP: strobes = 3'b110;
            default: strobes = 3'b111;
        endcase
        // Idle cycles alternate between deselect and an explicit no-operation
        o_pins.cs_b = (i_cmd == CMD_NOP) ? toggle : 1'b0;
        {o_pins.ras_b, o_pins.cas_b, o_pins.we_b} = strobes;
        o_pins.bank_sel = (i_cmd == CMD_NOP) ? {2{toggle}} : i_bank;
        o_pins.auto_close_flag = (i_cmd == CMD_NOP) ? toggle : i_close_all;
        o_pins.addr_low = (i_cmd == CMD_NOP) ? {8{toggle}} : i_addr;
        o_clk_en = i_cke;
    end
endmodule

// file: verification/sdcsl_top_tb_top.sv
// Self-checking bench for the SDRAM command-state logic.
// Assumes a 10 MHz clock and the controller model in front of the pins.
`timescale 1ns/100ps
module sdcsl_top_tb_top;
    import sdcsl_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    sdcsl_cmd_e cmd = CMD_NOP;
    logic [1:0] bank = 2'h0;
    logic close_all = 1'b0;
    logic [7:0] addr = 8'h00;
    logic cke = 1'b1;
    logic clk_en;
    sdcsl_pins_s pins;
    sdcsl_dev_e o_dev_state;
    sdcsl_bank_e o_bank_state [NUM_BANKS];
    logic o_illegal;
    logic o_clock_suspend;
    logic o_all_idle;
    sdcsl_ext_mode_s o_ext_mode;
    int miscompares = 0;
    int compares = 0;

    // ----------------------------------------
    // Clock, partner and design
    // ----------------------------------------
    always #50 i_clock = ~i_clock;

    sdcsl_ctrl_model ctrl (.i_clock(i_clock), .i_cmd(cmd), .i_bank(bank), .i_close_all(close_all),
        .i_addr(addr), .i_cke(cke), .o_clk_en(clk_en), .o_pins(pins));

    sdcsl_top #(.BANKS(NUM_BANKS)) uut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(clk_en),
        .i_pins(pins), .o_dev_state(o_dev_state), .o_bank_state(o_bank_state), .o_illegal(o_illegal),
        .o_clock_suspend(o_clock_suspend), .o_all_idle(o_all_idle), .o_ext_mode(o_ext_mode));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    // Present one request for one cycle, then look in the middle of that cycle
    task automatic iss(input sdcsl_cmd_e c, input logic [1:0] b, input logic ap, input logic [7:0] a,
        input logic k);
        @(posedge i_clock);
        cmd <= c;
        bank <= b;
        close_all <= ap;
        addr <= a;
        cke <= k;
        @(negedge i_clock);
    endtask

    task automatic nop(input logic k);
        iss(CMD_NOP, 2'h0, 1'b0, 8'h00, k);
    endtask

    // An x for the flag means the flag is not judged in that cycle
    task automatic st(input sdcsl_dev_e d, input sdcsl_bank_e b0, input sdcsl_bank_e b1, input logic il);
        chk(8'(o_dev_state), 8'(d));
        chk(8'(o_bank_state[0]), 8'(b0));
        chk(8'(o_bank_state[1]), 8'(b1));
        if (il !== 1'bx) begin
            chk(8'(o_illegal), 8'(il));
        end
    endtask

    // Bounded wait for a device state, low-power exits take a few cycles
    task automatic wait_dev(input sdcsl_dev_e d);
        int n;
        n = 0;
        while (o_dev_state !== d && n < 8) begin
            nop(1'b1);
            n++;
        end
        chk(8'(o_dev_state), 8'(d));
    endtask

    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_init;
        st(DEV_ALL_IDLE, BANK_IDLE, BANK_IDLE, 1'bx);
        chk(8'(o_clock_suspend), 8'h00);
        chk(8'(o_ext_mode), 8'({DRIVE_STRENGTH_HALF, PARTIAL_ARRAY_ALL}));
        repeat (POWERUP_WAIT_US * 10) nop(1'b1);
        iss(CMD_PRECHARGE, 2'h0, 1'b1, 8'h00, 1'b1);
        repeat (2) begin
            iss(CMD_REFRESH, 2'h0, 1'b0, 8'h00, 1'b1);
            nop(1'b1);
            nop(1'b1);
        end
        iss(CMD_MODE_LOAD, 2'h0, 1'b0, 8'h32, 1'b1);
        iss(CMD_ACTIVATE, 2'h0, 1'b0, 8'h00, 1'b1);
        st(DEV_MODE_ACCESS, BANK_IDLE, BANK_IDLE, 1'b1);
        nop(1'b1);
        st(DEV_MODE_ACCESS, BANK_IDLE, BANK_IDLE, 1'b0);
        nop(1'b1);
        st(DEV_ALL_IDLE, BANK_IDLE, BANK_IDLE, 1'b0);
        chk(8'(o_ext_mode), 8'({DRIVE_STRENGTH_HALF, PARTIAL_ARRAY_ALL}));
        $display("test init done");
    endtask

    task automatic t_banks;
        iss(CMD_ACTIVATE, 2'h0, 1'b0, 8'h11, 1'b1);
        iss(CMD_READ, 2'h0, 1'b0, 8'h00, 1'b1);
        // Device state follows the banks one cycle later
        st(DEV_ALL_IDLE, BANK_ACTIVATING, BANK_IDLE, 1'b1);
        iss(CMD_ACTIVATE, 2'h1, 1'b0, 8'h22, 1'b1);
        st(DEV_ACTIVE, BANK_ROW_ACTIVE, BANK_IDLE, 1'b0);
        iss(CMD_WRITE, 2'h0, 1'b0, 8'h00, 1'b1);
        st(DEV_ACTIVE, BANK_ROW_ACTIVE, BANK_ACTIVATING, 1'b0);
        iss(CMD_BURST_STOP, 2'h0, 1'b0, 8'h00, 1'b1);
        st(DEV_ACTIVE, BANK_BURST, BANK_ROW_ACTIVE, 1'bx);
        iss(CMD_PRECHARGE, 2'h0, 1'b0, 8'h00, 1'b1);
        st(DEV_ACTIVE, BANK_ROW_ACTIVE, BANK_ROW_ACTIVE, 1'b0);
        iss(CMD_ACTIVATE, 2'h0, 1'b0, 8'h00, 1'b1);
        st(DEV_ACTIVE, BANK_PRECHARGING, BANK_ROW_ACTIVE, 1'b1);
        iss(CMD_PRECHARGE, 2'h0, 1'b1, 8'h00, 1'b1);
        st(DEV_ACTIVE, BANK_IDLE, BANK_ROW_ACTIVE, 1'b0);
        nop(1'b1);
        st(DEV_ACTIVE, BANK_IDLE, BANK_PRECHARGING, 1'b0);
        chk(8'(o_all_idle), 8'h00);
        nop(1'b1);
        chk(8'(o_all_idle), 8'h01);
        $display("test banks done");
    endtask

    task automatic t_suspend;
        iss(CMD_ACTIVATE, 2'h2, 1'b0, 8'h33, 1'b1);
        nop(1'b1);
        repeat (3) nop(1'b0);
        iss(CMD_READ, 2'h2, 1'b0, 8'h00, 1'b0);
        nop(1'b0);
        chk(8'(o_clock_suspend), 8'h01);
        chk(8'(o_bank_state[2]), 8'(BANK_ROW_ACTIVE));
        chk(8'(o_dev_state == DEV_POWER_DOWN), 8'h00);
        repeat (3) nop(1'b1);
        chk(8'(o_clock_suspend), 8'h00);
        iss(CMD_ACTIVATE, 2'h3, 1'b0, 8'h44, 1'b1);
        nop(1'b1);
        iss(CMD_MODE_LOAD, 2'h2, 1'b0, 8'h45, 1'b1);
        chk(8'(o_illegal), 8'h01);
        iss(CMD_PRECHARGE, 2'h0, 1'b1, 8'h00, 1'b1);
        chk(8'(o_ext_mode), 8'({DRIVE_STRENGTH_HALF, PARTIAL_ARRAY_ALL}));
        nop(1'b1);
        nop(1'b1);
        iss(CMD_MODE_LOAD, 2'h2, 1'b0, 8'h45, 1'b1);
        repeat (3) nop(1'b1);
        chk(8'(o_ext_mode), 8'h15);
        $display("test suspend done");
    endtask

    task automatic t_low_power;
        repeat (5) nop(1'b0);
        chk(8'(o_dev_state), 8'(DEV_POWER_DOWN));
        wait_dev(DEV_ALL_IDLE);
        nop(1'b1);
        iss(CMD_REFRESH, 2'h0, 1'b0, 8'h00, 1'b0);
        repeat (5) nop(1'b0);
        chk(8'(o_dev_state), 8'(DEV_SELF_REFRESH));
        wait_dev(DEV_ALL_IDLE);
        $display("test low power done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(negedge i_clock);
        t_init();
        t_banks();
        t_suspend();
        t_low_power();
        end_of_test();
    end

    initial begin
        #600000;
        miscompares++;
        end_of_test();
    end
endmodule
